/* File: verilog/mcd_pkg.sv */
// constants, field layout and register map of the instruction decoder
package mcd_pkg;

   // --------------------------------------------------------------
   // widths
   // --------------------------------------------------------------
   localparam int WORD_W  = 16;
   localparam int PC_W    = 21;
   localparam int TBL_W   = 21;
   localparam int LAT_W   = 8;
   localparam int FLAG_W  = 5;
   localparam int BANK_W  = 4;
   localparam int FADR_W  = 12;
   localparam int RADR_W  = 8;
   localparam int RDAT_W  = 32;

   // --------------------------------------------------------------
   // field positions inside a program word
   // --------------------------------------------------------------
   localparam int NIB_HI  = 15;
   localparam int NIB_LO  = 12;
   localparam int PFX_LO  = 8;
   localparam int DST_BIT = 9;
   localparam int ACC_BIT = 8;
   localparam int F_HI    = 7;
   localparam int BIT_HI  = 11;
   localparam int BIT_LO  = 9;
   localparam int F12_HI  = 11;
   localparam int K12_HI  = 3;
   localparam int PTR_LO  = 4;
   localparam int PTR_HI  = 5;
   localparam int REL_HI  = 10;
   localparam int OFS_HI  = 6;
   localparam int FAST_BIT = 0;
   localparam int MODE_HI = 1;

   localparam logic [3:0] NIB_SECOND = 4'hf;
   localparam logic [3:0] NIB_MOVFF  = 4'hc;

   // --------------------------------------------------------------
   // table pointer modes
   // --------------------------------------------------------------
   localparam logic [1:0] TBL_KEEP    = 2'h0;
   localparam logic [1:0] TBL_POSTINC = 2'h1;
   localparam logic [1:0] TBL_POSTDEC = 2'h2;
   localparam logic [1:0] TBL_PREINC  = 2'h3;

   // --------------------------------------------------------------
   // status flag positions
   // --------------------------------------------------------------
   localparam int FLG_C   = 0;
   localparam int FLG_DCY = 1;
   localparam int FLG_Z   = 2;
   localparam int FLG_OVF = 3;
   localparam int FLG_N   = 4;

   // --------------------------------------------------------------
   // timing
   // --------------------------------------------------------------
   localparam int         OSC_PER_CYCLE = 4;
   localparam logic [1:0] Q_LAST = 2'(OSC_PER_CYCLE - 1);
   localparam logic [1:0] CYC_ONE   = 2'h1;
   localparam logic [1:0] CYC_TWO   = 2'h2;
   localparam logic [1:0] CYC_THREE = 2'h3;

   // --------------------------------------------------------------
   // register map
   // --------------------------------------------------------------
   localparam logic [7:0] REG_CTRL   = 8'h00;
   localparam logic [7:0] REG_BANK   = 8'h04;
   localparam logic [7:0] REG_FLAGS  = 8'h08;
   localparam logic [7:0] REG_TPTR   = 8'h0c;
   localparam logic [7:0] REG_TBLLAT = 8'h10;
   localparam logic [7:0] REG_CYCLES = 8'h14;
   localparam int CTRL_RUN = 0;
   localparam int CTRL_EXT = 1;

   typedef enum logic [1:0] {
      ST_EXEC,
      ST_WORD2,
      ST_SKIP2,
      ST_NOP
   } mcd_state_type;

endpackage

/* File: verilog/mcd_fields_if.sv */
// field bundle between the word splitter and the issue logic
interface mcd_fields_if;
   import mcd_pkg::*;
   logic [WORD_W-1:0] word1;
   logic [WORD_W-1:0] word2;
   logic              dest_file;
   logic              banked;
   logic [2:0]        bit_sel;
   logic [7:0]        file_f;
   logic [1:0]        ptr_sel;
   logic [FADR_W-1:0] src_addr;
   logic [FADR_W-1:0] dst_addr;
   logic [7:0]        lit8;
   logic [11:0]       lit12;
   logic [19:0]       lit20;
   logic              fast;
   logic [1:0]        tbl_mode;
   logic [10:0]       rel_long;
   logic [7:0]        rel_short;
   logic [6:0]        ofs_src;
   logic [6:0]        ofs_dst;

   modport split (
      input  word1, word2,
      output dest_file, banked, bit_sel, file_f, ptr_sel, src_addr,
             dst_addr, lit8, lit12, lit20, fast, tbl_mode, rel_long,
             rel_short, ofs_src, ofs_dst
   );
   modport use_side (
      output word1, word2,
      input  dest_file, banked, bit_sel, file_f, ptr_sel, src_addr,
             dst_addr, lit8, lit12, lit20, fast, tbl_mode, rel_long,
             rel_short, ofs_src, ofs_dst
   );
endinterface

/* File: verilog/mcd_field_split.sv */
// splits one or two program words into operand fields
module mcd_field_split
   import mcd_pkg::*;
(
   mcd_fields_if.split f
);
   // bits not named by a field are never looked at, whatever they hold
   assign f.dest_file = f.word1[DST_BIT];                       // RULE_03
   assign f.banked    = f.word1[ACC_BIT];                       // RULE_04
   assign f.bit_sel   = f.word1[BIT_HI:BIT_LO];                 // RULE_05
   assign f.file_f    = f.word1[F_HI:0];                        // RULE_11
   assign f.ptr_sel   = f.word1[PTR_HI:PTR_LO];                 // RULE_11
   assign f.src_addr  = f.word1[F12_HI:0];                      // RULE_12
   assign f.dst_addr  = f.word2[F12_HI:0];                      // RULE_12
   assign f.lit8      = f.word1[F_HI:0];                        // RULE_16
   assign f.lit12     = {f.word1[K12_HI:0], f.word2[F_HI:0]};   // RULE_16
   assign f.lit20     = {f.word2[F12_HI:0], f.word1[F_HI:0]};   // RULE_16
   assign f.fast      = f.word1[FAST_BIT];                      // RULE_13
   assign f.tbl_mode  = f.word1[MODE_HI:0];                     // RULE_14
   assign f.rel_long  = f.word1[REL_HI:0];                      // RULE_18
   assign f.rel_short = f.word1[F_HI:0];                        // RULE_18
   assign f.ofs_src   = f.word1[OFS_HI:0];                      // RULE_17
   assign f.ofs_dst   = f.word2[OFS_HI:0];                      // RULE_17
endmodule

/* File: verilog/mcd_decode_top.sv */
// instruction fetch, decode and issue timing for the 8-bit core
// Function
// RULE_01: decode standard set plus eight extended instructions
// RULE_02: one-word instructions, four two-word instructions
// RULE_03: destination bit picks accumulator or file register
// RULE_04: access bit picks access RAM or bank
// RULE_05: three-bit field names bit 0 to 7
// RULE_06: second word has top nibble ones, runs NOP
// RULE_07: one-word: one cycle, two if taken
// RULE_08: two-word instructions take two cycles
// RULE_09: taken skip over two-word takes three
// RULE_10: four oscillator periods per instruction cycle
// RULE_11: file field is address or pointer selector
// RULE_12: register move carries two 12-bit addresses
// RULE_13: fast bit selects shadow save or restore
// RULE_14: table mode: keep, post-inc, post-dec, pre-inc
// RULE_15: 21-bit table pointer, 8-bit table latch
// RULE_16: literals are 8, 12 or 20 bits
// RULE_17: indexed addressing has two 7-bit offsets
// RULE_18: address field relative or absolute target
// RULE_19: five status flags kept for the ALU
// RULE_20: don't-care bits never change behaviour
// RULE_21: program counter change flushes the prefetched word; the code honours i_pc_change only at the end of a one-word instruction
//
// The plain strobed port and the register addresses are this design's own decisions.
module mcd_decode_top
   import mcd_pkg::*;
#(
   // two-word and extended opcode prefixes (upper byte), values and masks, and the access RAM split
   parameter logic [7:0] TW0_CODE    = 8'he0,
   parameter logic [7:0] TW1_CODE    = 8'he2,
   parameter logic [7:0] TW_MASK     = 8'hfe,
   parameter logic [7:0] EXT_CODE    = 8'he8,
   parameter logic [7:0] EXT_MASK    = 8'hf8,
   parameter logic [7:0] ACCESS_SPLIT = 8'h80
)(
   input  wire logic              i_mclk,
   input  wire logic              i_sys_rst,
   input  wire logic [RADR_W-1:0] i_reg_addr,
   input  wire logic [RDAT_W-1:0] i_reg_wdata,
   input  wire logic              i_reg_wr,
   input  wire logic              i_reg_rd,
   output logic      [RDAT_W-1:0] o_reg_rdata,
   output logic      [PC_W-1:0]   o_prog_addr,
   input  wire logic [WORD_W-1:0] i_prog_word,
   input  wire logic              i_cond_true,
   input  wire logic              i_pc_change,
   input  wire logic [PC_W-1:0]   i_new_pc,
   input  wire logic [FLAG_W-1:0] i_flag_we,
   input  wire logic [FLAG_W-1:0] i_flag_val,
   input  wire logic              i_tbl_req,
   input  wire logic              i_tbl_write,
   input  wire logic [LAT_W-1:0]  i_tbl_rdata,
   output logic      [1:0]        o_qphase,
   output logic                   o_issue,
   output logic                   o_flush,
   output logic      [WORD_W-1:0] o_insn_word,
   output logic      [WORD_W-1:0] o_insn_word2,
   output logic                   o_two_word,
   output logic                   o_is_nop,
   output logic                   o_is_ext,
   output logic                   o_dest_file,
   output logic      [FADR_W-1:0] o_file_addr,
   output logic      [2:0]        o_bit_sel,
   output logic      [1:0]        o_ptr_sel,
   output logic      [FADR_W-1:0] o_src_addr,
   output logic      [FADR_W-1:0] o_dst_addr,
   output logic      [7:0]        o_lit8,
   output logic      [11:0]       o_lit12,
   output logic      [19:0]       o_lit20,
   output logic                   o_fast,
   output logic      [1:0]        o_tbl_mode,
   output logic      [PC_W-1:0]   o_rel_long,
   output logic      [PC_W-1:0]   o_rel_short,
   output logic      [6:0]        o_ofs_src,
   output logic      [6:0]        o_ofs_dst,
   output logic      [FLAG_W-1:0] o_flags,
   output logic      [BANK_W-1:0] o_bank,
   output logic      [TBL_W-1:0]  o_tbl_addr,
   output logic      [LAT_W-1:0]  o_tbl_wdata,
   output logic      [1:0]        o_last_cycles
);

   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   function automatic logic is_first_of_two(input logic [WORD_W-1:0] w);
      logic [7:0] p;
      p = w[NIB_HI:PFX_LO];
      is_first_of_two = (w[NIB_HI:NIB_LO] == NIB_MOVFF) ||
                        ((p & TW_MASK) == TW0_CODE) ||
                        ((p & TW_MASK) == TW1_CODE);          // RULE_02
   endfunction

   function automatic logic is_second(input logic [WORD_W-1:0] w);
      is_second = (w[NIB_HI:NIB_LO] == NIB_SECOND);            // RULE_06
   endfunction

   function automatic logic [PC_W-1:0] sext8(input logic [7:0] v);
      sext8 = {{(PC_W-8){v[7]}}, v};
   endfunction

   function automatic logic [TBL_W-1:0] tbl_inc(input logic [TBL_W-1:0] v);
      tbl_inc = v + TBL_W'(1);
   endfunction

   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   typedef struct packed {
      mcd_state_type     st;
      logic [1:0]        q;
      logic [PC_W-1:0]   pc;
      logic [WORD_W-1:0] ir1;
      logic [WORD_W-1:0] ir2;
      logic              two;
      logic              issue;
      logic              flush;
      logic [1:0]        cyc;
      logic [1:0]        last_cyc;
      logic              run;
      logic              ext_en;
      logic [BANK_W-1:0] bank;
      logic [FLAG_W-1:0] flags;
      logic [TBL_W-1:0]  tptr;
      logic [LAT_W-1:0]  tlat;
      logic [RDAT_W-1:0] rdata;
   } mcd_core_type;

   mcd_core_type s_reg;
   mcd_core_type s_next;

   mcd_fields_if fld ();

   assign fld.word1 = s_reg.ir1;
   assign fld.word2 = s_reg.ir2;

   mcd_field_split u_split (
      .f (fld.split)
   );

   logic boundary;
   logic cur_single;
   logic taken;
   logic [FLAG_W-1:0] hw_flags;
   logic [TBL_W-1:0]  tbl_step;

   assign boundary   = s_reg.run && (s_reg.q == Q_LAST);       // RULE_10
   assign cur_single = (s_reg.st == ST_EXEC) && !s_reg.two;
   assign taken      = cur_single && (i_cond_true || i_pc_change);
   assign hw_flags   = (s_reg.flags & ~i_flag_we) |
                       (i_flag_val & i_flag_we);               // RULE_19

   always_comb begin
      tbl_step = s_reg.tptr;
      case (fld.tbl_mode)                                      // RULE_14
         TBL_POSTINC: tbl_step = tbl_inc(s_reg.tptr);
         TBL_POSTDEC: tbl_step = s_reg.tptr - TBL_W'(1);
         TBL_PREINC:  tbl_step = tbl_inc(s_reg.tptr);
         default:     tbl_step = s_reg.tptr;
      endcase
   end

   // ---------------------------------------------------------------
   // next state
   // ---------------------------------------------------------------
   always_comb begin
      s_next       = s_reg;
      s_next.issue = 1'b0;
      s_next.flush = 1'b0;
      s_next.rdata = '0;

      // quarter phase counter, held at zero while stopped
      if (s_reg.run) begin
         s_next.q = s_reg.q + 2'h1;                            // RULE_10
      end else begin
         s_next.q = '0;
      end

      if (boundary) begin
         s_next.pc = s_reg.pc + PC_W'(1);
         case (s_reg.st)
            ST_EXEC, ST_NOP: begin
               if (taken) begin
                  // prefetched word is thrown away, a nop runs instead
                  s_next.flush = 1'b1;                         // RULE_21
                  s_next.cyc   = CYC_TWO;                      // RULE_07
                  s_next.ir1   = '0;
                  s_next.two   = 1'b0;
                  if (i_pc_change) begin
                     s_next.pc = i_new_pc;
                     s_next.st = ST_NOP;
                  end else if (is_first_of_two(i_prog_word)) begin
                     s_next.st = ST_SKIP2;                     // RULE_09
                  end else begin
                     s_next.st = ST_NOP;
                  end
               end else begin
                  if (s_reg.st == ST_EXEC) begin
                     s_next.last_cyc = s_reg.cyc;
                  end
                  s_next.ir1 = i_prog_word;
                  s_next.ir2 = '0;
                  if (is_first_of_two(i_prog_word)) begin
                     s_next.two = 1'b1;
                     s_next.st  = ST_WORD2;                    // RULE_02
                  end else begin
                     s_next.two   = 1'b0;
                     s_next.cyc   = CYC_ONE;                   // RULE_07
                     s_next.issue = 1'b1;
                     s_next.st    = ST_EXEC;
                  end
               end
               if (s_reg.st == ST_NOP) begin
                  s_next.last_cyc = s_reg.cyc;
               end
            end
            ST_WORD2: begin
               s_next.ir2   = i_prog_word;
               s_next.cyc   = CYC_TWO;                         // RULE_08
               s_next.issue = 1'b1;
               s_next.st    = ST_EXEC;
            end
            ST_SKIP2: begin
               s_next.flush = 1'b1;
               s_next.cyc   = CYC_THREE;                       // RULE_09
               s_next.st    = ST_NOP;
            end
            default: s_next.st = ST_EXEC;
         endcase
      end

      // table transfers
      if (i_tbl_req) begin
         s_next.tptr = tbl_step;                               // RULE_15
         if (!i_tbl_write) begin
            s_next.tlat = i_tbl_rdata;                         // RULE_15
         end
      end

      // register writes; the datapath wins over software on flags
      if (i_reg_wr) begin
         case (i_reg_addr)
            REG_CTRL: begin
               s_next.run    = i_reg_wdata[CTRL_RUN];
               s_next.ext_en = i_reg_wdata[CTRL_EXT];          // RULE_01
            end
            REG_BANK:   s_next.bank  = i_reg_wdata[BANK_W-1:0];
            REG_FLAGS:  s_next.flags = i_reg_wdata[FLAG_W-1:0];
            REG_TPTR:   if (!i_tbl_req) begin
               s_next.tptr = i_reg_wdata[TBL_W-1:0];
            end
            REG_TBLLAT: if (!i_tbl_req) begin
               s_next.tlat = i_reg_wdata[LAT_W-1:0];
            end
            default: s_next.run = s_reg.run;
         endcase
      end
      if (|i_flag_we) begin
         s_next.flags = (i_reg_wr && i_reg_addr == REG_FLAGS) ?
                        ((i_reg_wdata[FLAG_W-1:0] & ~i_flag_we) |
                         (i_flag_val & i_flag_we)) :
                        hw_flags;                              // RULE_19
      end

      // register reads, answered one cycle later
      if (i_reg_rd) begin
         case (i_reg_addr)
            REG_CTRL: begin
               s_next.rdata[CTRL_RUN] = s_reg.run;
               s_next.rdata[CTRL_EXT] = s_reg.ext_en;
            end
            REG_BANK:   s_next.rdata[BANK_W-1:0] = s_reg.bank;
            REG_FLAGS:  s_next.rdata[FLAG_W-1:0] = s_reg.flags;
            REG_TPTR:   s_next.rdata[TBL_W-1:0]  = s_reg.tptr;
            REG_TBLLAT: s_next.rdata[LAT_W-1:0]  = s_reg.tlat;
            REG_CYCLES: s_next.rdata[1:0]        = s_reg.last_cyc;
            default:    s_next.rdata = '0;
         endcase
      end
   end

   // ---------------------------------------------------------------
   // registers
   // ---------------------------------------------------------------
   always_ff @(posedge i_mclk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end

   // ---------------------------------------------------------------
   // outputs
   // ---------------------------------------------------------------
   logic [7:0] f8;
   logic [3:0] acc_hi;
   logic [7:0] pfx;

   assign f8     = fld.file_f;
   assign pfx    = s_reg.ir1[NIB_HI:PFX_LO];
   // access RAM: low part maps to bank zero, high part to the top bank
   assign acc_hi = (f8 < ACCESS_SPLIT) ? 4'h0 : 4'hf;

   assign o_reg_rdata  = s_reg.rdata;
   assign o_prog_addr  = s_reg.pc;
   assign o_qphase     = s_reg.q;
   assign o_issue      = s_reg.issue;
   assign o_flush      = s_reg.flush;
   assign o_insn_word  = s_reg.ir1;
   assign o_insn_word2 = s_reg.ir2;
   assign o_two_word   = s_reg.two;
   // a lone second word or a flushed slot runs as a nop
   assign o_is_nop     = (s_reg.st != ST_EXEC) ||
                         (!s_reg.two && is_second(s_reg.ir1)); // RULE_06
   assign o_is_ext     = s_reg.ext_en && !s_reg.two &&
                         ((pfx & EXT_MASK) == EXT_CODE);       // RULE_01
   assign o_dest_file  = fld.dest_file;                        // RULE_03
   assign o_file_addr  = fld.banked ? {s_reg.bank, f8} :
                                      {acc_hi, f8};            // RULE_04
   assign o_bit_sel    = fld.bit_sel;
   assign o_ptr_sel    = fld.ptr_sel;
   assign o_src_addr   = fld.src_addr;
   assign o_dst_addr   = fld.dst_addr;
   assign o_lit8       = fld.lit8;
   assign o_lit12      = fld.lit12;
   assign o_lit20      = fld.lit20;
   assign o_fast       = fld.fast;                             // RULE_13
   assign o_tbl_mode   = fld.tbl_mode;
   assign o_rel_long   = {{(PC_W-11){fld.rel_long[10]}},
                          fld.rel_long};                       // RULE_18
   assign o_rel_short  = sext8(fld.rel_short);                 // RULE_18
   assign o_ofs_src    = fld.ofs_src;
   assign o_ofs_dst    = fld.ofs_dst;
   assign o_flags      = s_reg.flags;
   assign o_bank       = s_reg.bank;
   // pre-increment presents the advanced pointer on this access
   assign o_tbl_addr   = (fld.tbl_mode == TBL_PREINC) ?
                         tbl_inc(s_reg.tptr) : s_reg.tptr;
   assign o_tbl_wdata  = s_reg.tlat;
   assign o_last_cycles = s_reg.last_cyc;

endmodule

/* File: bench/mcd_prog_mem.sv */
// program memory model feeding the decoder's fetch port
module mcd_prog_mem
   import mcd_pkg::*;
(
   input  wire logic [PC_W-1:0]   i_addr,
   output logic      [WORD_W-1:0] o_word
);
   timeunit 1ns;
   timeprecision 1ps;
   // ------------------------
   // storage
   // ------------------------
   // unloaded words read as zero, the form code generators emit
   logic [WORD_W-1:0] mem [256] = '{default: 16'h0000};
   // combinational answer, always driven, one full word per address
   assign o_word = mem[i_addr[7:0]];
endmodule

/* File: bench/mcd_decode_sva.sv */
// port assertions for the instruction decoder
module mcd_decode_sva
   import mcd_pkg::*;
(
   input wire logic              i_mclk,
   input wire logic              i_sys_rst,
   input wire logic              i_reg_rd,
   input wire logic [RDAT_W-1:0] o_reg_rdata,
   input wire logic [1:0]        o_qphase,
   input wire logic              o_issue,
   input wire logic              o_flush,
   input wire logic              o_is_nop,
   input wire logic [WORD_W-1:0] o_insn_word,
   input wire logic [WORD_W-1:0] o_insn_word2,
   input wire logic              o_two_word,
   input wire logic [19:0]       o_lit20,
   input wire logic [FADR_W-1:0] o_src_addr,
   input wire logic [FADR_W-1:0] o_dst_addr,
   input wire logic [2:0]        o_bit_sel
);
   timeunit 1ns;
   timeprecision 1ps;
   // ------------------------
   // sequences
   // ------------------------
   default clocking cb @(posedge i_mclk);
   endclocking
   default disable iff (i_sys_rst);
   sequence s_pulse;
      o_issue ##1 !o_issue [*3];
   endsequence
   sequence s_lone;
      o_issue && o_insn_word[NIB_HI:NIB_LO] == NIB_SECOND;
   endsequence
   sequence s_move;
      o_issue && o_insn_word[NIB_HI:NIB_LO] == NIB_MOVFF;
   endsequence
   // ------------------------
   // assertions
   // ------------------------
   a_q_step: assert property (
      o_qphase != 2'h0 |=> o_qphase == 2'($past(o_qphase) + 2'h1))
      else $error("quarter phase skipped");
   a_issue_gap: assert property (
      o_issue |-> s_pulse)
      else $error("issue closer than four clocks");
   a_issue_q0: assert property (
      o_issue |-> o_qphase == 2'h0)
      else $error("issue off the cycle start");
   a_rdata_idle: assert property (
      !$past(i_reg_rd) |-> o_reg_rdata == '0)
      else $error("read data outside its cycle");
   a_flush_nop: assert property (
      o_flush |-> o_is_nop)
      else $error("flushed slot not a nop");
   a_lone_nop: assert property (
      s_lone |-> o_is_nop)
      else $error("lone second word not a nop");
   a_move_pair: assert property (
      s_move |-> o_two_word && o_src_addr == o_insn_word[11:0]
                 && o_dst_addr == o_insn_word2[11:0])
      else $error("move addresses wrong");
   a_lit20_join: assert property (
      o_issue && o_two_word |->
         o_lit20 == {o_insn_word2[11:0], o_insn_word[7:0]})
      else $error("long literal wrong");
   a_bit_field: assert property (
      o_issue |-> o_bit_sel == o_insn_word[BIT_HI:BIT_LO])
      else $error("bit number wrong");
endmodule

/* File: bench/tb_mcd_decode_top.sv */
// self-checking bench for the instruction decoder
module tb_mcd_decode_top
   import mcd_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic              i_mclk = 1'b0, i_sys_rst = 1'b1;
   logic [RADR_W-1:0] i_reg_addr = '0;
   logic [RDAT_W-1:0] i_reg_wdata = '0, o_reg_rdata;
   logic              i_reg_wr = 1'b0, i_reg_rd = 1'b0, i_tbl_req = 1'b0;
   logic              i_cond_true = 1'b0, i_pc_change = 1'b0;
   logic              i_tbl_write = 1'b0, o_dest_file, o_fast;
   logic [PC_W-1:0]   i_new_pc = '0, o_prog_addr, o_tbl_addr;
   logic [PC_W-1:0]   o_rel_long, o_rel_short;
   logic [FLAG_W-1:0] i_flag_we = '0, i_flag_val = '0, o_flags;
   logic [LAT_W-1:0]  i_tbl_rdata = '0, o_lit8, o_tbl_wdata;
   logic [WORD_W-1:0] i_prog_word, o_insn_word, o_insn_word2;
   logic [1:0]        o_qphase, o_ptr_sel, o_tbl_mode, o_last_cycles;
   logic              o_issue, o_flush, o_two_word, o_is_nop, o_is_ext;
   logic [FADR_W-1:0] o_file_addr, o_src_addr, o_dst_addr;
   logic [11:0]       o_lit12;
   logic [19:0]       o_lit20;
   logic [2:0]        o_bit_sel;
   logic [6:0]        o_ofs_src, o_ofs_dst;
   logic [BANK_W-1:0] o_bank;
   logic [31:0]       d;
   int                n_mismatch = 0, checks_done = 0, n_flush = 0;
   int                cyc = 0;
   time               t_iss = 0, t_gap = 0;

   mcd_decode_top u_dut (.*);
   mcd_prog_mem u_mem (.i_addr(o_prog_addr), .o_word(i_prog_word));

   always #10 i_mclk = ~i_mclk;
   always @(negedge i_mclk) begin
      if (o_flush === 1'b1) begin
         n_flush++;
      end
   end
   // hang guard: the whole run needs about 110 clocks
   always @(posedge i_mclk) begin
      cyc++;
      if (cyc > 3000) begin
         n_mismatch++;
         report_and_stop();
      end
   end
   // ------------------------
   // helpers
   // ------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         n_mismatch++;
         $display("BAD %0t got %h want %h", $time, got, exp);
      end
   endtask
   task automatic reg_wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge i_mclk);
      i_reg_addr <= a;
      i_reg_wdata <= v;
      i_reg_wr <= 1'b1;
      @(posedge i_mclk);
      i_reg_wr <= 1'b0;
   endtask
   task automatic reg_rd(input logic [7:0] a);
      @(posedge i_mclk);
      i_reg_addr <= a;
      i_reg_rd <= 1'b1;
      @(posedge i_mclk);
      i_reg_rd <= 1'b0;
      @(negedge i_mclk);
      d = o_reg_rdata;
   endtask
   task automatic next_issue(input logic [15:0] w);
      int n;
      n = 0;
      do begin
         @(negedge i_mclk);
         n++;
      end while (o_issue !== 1'b1 && n < 40);
      t_gap = $time - t_iss;
      t_iss = $time;
      chk(o_insn_word, w);
   endtask
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   // ------------------------
   // scenarios
   // ------------------------
   task automatic t_regs();
      logic [7:0] offs [7];
      offs = '{REG_CTRL, REG_BANK, REG_FLAGS, REG_TPTR, REG_TBLLAT,
               REG_CYCLES, 8'h18};
      foreach (offs[i]) begin
         reg_rd(offs[i]);
         chk(d, 32'h0);
      end
      reg_wr(REG_BANK, 32'hffffffff);
      reg_rd(REG_BANK);
      chk(d, 32'hf);
      reg_wr(REG_CYCLES, 32'h3);
      reg_rd(REG_CYCLES);
      chk(d, 32'h0);
      reg_wr(REG_TPTR, 32'hffffffff);
      reg_rd(REG_TPTR);
      chk(d, 32'h1fffff);
      reg_wr(REG_FLAGS, 32'h1f);
      reg_rd(REG_FLAGS);
      chk(d, 32'h1f);
      @(posedge i_mclk);
      i_flag_we <= 5'h04;
      @(posedge i_mclk);
      i_flag_we <= 5'h00;
      @(negedge i_mclk);
      chk(o_flags, 5'h1b);
      reg_wr(REG_BANK, 32'h5);
      reg_wr(REG_TPTR, 32'h100);
   endtask
   task automatic t_fields();
      reg_wr(REG_CTRL, 32'h3);
      next_issue(16'h2754);
      chk(o_dest_file, 1'b1);
      chk(o_file_addr, 12'h554);
      chk(o_bank, 4'h5);
      chk(o_rel_long, 21'h1fff54);
      chk(o_lit8, 8'h54);
      chk(o_ptr_sel, 2'h1);
      next_issue(16'hc123);
      chk(o_two_word, 1'b1);
      chk(o_dst_addr, 12'h456);
      chk(o_ofs_dst, 7'h56);
      chk(o_lit12, 12'h356);
      chk(o_ofs_src, 7'h23);
      next_issue(16'hf000);
      chk(o_is_nop, 1'b1);
      next_issue(16'he0ab);
      chk(o_lit20, 20'h123ab);
      chk(o_rel_short, 21'h1fffab);
      next_issue(16'h000a);
      chk(o_last_cycles, 2'h2);
      chk(o_tbl_mode, TBL_POSTDEC);
      @(posedge i_mclk);
      i_tbl_rdata <= 8'h5a;
      i_tbl_req <= 1'b1;
      @(posedge i_mclk);
      i_tbl_req <= 1'b0;
      next_issue(16'h000b);
      chk(o_tbl_addr, 21'h100);
      chk(o_fast, 1'b1);
      chk(o_tbl_wdata, 8'h5a);
   endtask
   task automatic t_flow();
      next_issue(16'h0010);
      @(posedge i_mclk);
      i_pc_change <= 1'b1;
      i_new_pc <= 21'h14;
      next_issue(16'he820);
      chk(t_gap, 32'ha0);
      chk(o_is_ext, 1'b1);
      chk(o_prog_addr, 21'h15);
      chk(o_last_cycles, 2'h2);
      @(posedge i_mclk);
      i_pc_change <= 1'b0;
      i_cond_true <= 1'b1;
      next_issue(16'h0030);
      chk(t_gap, 32'hf0);
      chk(o_last_cycles, 2'h3);
      chk(o_file_addr, 12'h030);
      chk(o_is_ext, 1'b0);
      chk(n_flush, 32'h3);
      @(posedge i_mclk);
      i_cond_true <= 1'b0;
      reg_rd(REG_TPTR);
      chk(d, 32'hff);
      reg_rd(REG_TBLLAT);
      chk(d, 32'h5a);
   endtask
   initial begin
      u_mem.mem[0] = 16'h2754;
      u_mem.mem[1] = 16'hc123;
      u_mem.mem[2] = 16'hf456;
      u_mem.mem[3] = 16'hf000;
      u_mem.mem[4] = 16'he0ab;
      u_mem.mem[5] = 16'hf123;
      u_mem.mem[6] = 16'h000a;
      u_mem.mem[7] = 16'h000b;
      u_mem.mem[8] = 16'h0010;
      u_mem.mem[20] = 16'he820;
      u_mem.mem[21] = 16'hc001;
      u_mem.mem[22] = 16'hf002;
      u_mem.mem[23] = 16'h0030;
      repeat (8) @(posedge i_mclk);
      i_sys_rst <= 1'b0;
      t_regs();
      t_fields();
      t_flow();
      report_and_stop();
   end
endmodule

bind mcd_decode_top mcd_decode_sva u_sva (.*);
